// [ocstp_capture.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// capture-side model: sync reset pin driven from its own clock
// ****************************************
module ocstp_capture (
    // request from the bench and calibration state
    input wire logic want_rst,
    input wire logic cal_busy,
    // device clock being watched
    input wire logic data_clk,
    // sync reset pin and count of data clock rises
    output logic sync_rst,
    output logic [15:0] edge_cnt
);
    logic link_clk;
    logic pin_r = 1'b0;
    logic [15:0] cnt_r = 16'h0000;
    // link clock, phase kept off the sampling grid so no edge races it
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #62.5 link_clk = ~link_clk;
    end
    // pin rises only outside calibration and drops as soon as asked
    always @(posedge link_clk) begin
        pin_r <= want_rst & (pin_r | ~cal_busy);
    end
    // count rises of the captured data clock
    always @(posedge data_clk) begin
        cnt_r <= cnt_r + 16'h0001;
    end
    assign sync_rst = pin_r;
    assign edge_cnt = cnt_r;
endmodule : ocstp_capture
`default_nettype wire

// [ocstp_pkg.sv]
`default_nettype none
package ocstp_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] OFFS_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam int CTRL_DEMUX = 0;
    localparam int CTRL_DDR = 1;
    localparam int CTRL_EDGE = 2;
    localparam int CTRL_RUN = 3;
    localparam int CTRL_TEST = 4;
    localparam logic [4:0] CTRL_RST = 5'h01;
    localparam int OFFS_Q_LSB = 16;
    localparam int OFFS_W = 9;
    localparam logic [8:0] OFFS_RST = 9'h000;
    // ****************************************
    // test pattern words and sequences
    // ****************************************
    localparam logic [7:0] PAT_QL = 8'h01;
    localparam logic [7:0] PAT_IL = 8'h02;
    localparam logic [7:0] PAT_Q = 8'h03;
    localparam logic [7:0] PAT_I = 8'h04;
    localparam logic [4:0] DMX_SEQ = 5'h0a;
    localparam logic [9:0] NDM_SEQ = 10'h132;
    localparam logic [3:0] DMX_LAST = 4'h4;
    localparam logic [3:0] NDM_LAST = 4'h9;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 8;
    localparam int TOD_NS = 8;
    localparam int TOD_CYC = (TOD_NS + CLK_NS - 1) / CLK_NS < 1 ? 1
                           : (TOD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] WAIT_DDR0 = 4'h4;
    localparam logic [3:0] WAIT_OTHER = 4'h3;
    localparam logic [1:0] SLOT_DMX_LAST = 2'h3;
    localparam logic [1:0] SLOT_NDM_LAST = 2'h1;
    localparam logic [1:0] DMX_MID = 2'h1;
    // ****************************************
    // sample format: 4 fraction bits per code
    // ****************************************
    localparam int FRAC_W = 4;
    localparam int NEG_ZERO_STEP = 2;
    typedef enum logic [1:0] {OCSTP_RUN, OCSTP_HOLD, OCSTP_WAIT} ocstp_state_t;
endpackage : ocstp_pkg
`default_nettype wire

// [ocstp_top.sv]
// Notes on behaviour
// - sync reset may assert at any time, unaligned to the sampling clock
// - while sync reset is held, data clock sits at a mode-chosen level
// - asserting sync reset may cut the data clock into a narrow pulse
// - release takes effect on the next sampling clock edge and aligns devices
// - wait four cycles in demux DDR 0-degree mode, three otherwise
// - data clock restarts after a further fixed clock-to-output delay
// - data clock stops during calibration unless continuous run is set
// - test mode replaces samples on all four buses and range flag
// - pattern is the same with or without interleaving
// - demux buses carry 01h, 02h, 03h, 04h with range flag low
// - complements FEh..FBh with flag high; demux sequence of five words
// - non-demux: two primary buses only, flag high on complements
// - without sync the two channels may slip by one clock period
// - pattern starts on the buses when sync reset is released
// - pattern runs at full rate in SDR, DDR and non-demux modes
// - out of range input clips to extreme code and raises range flag
// - offset is sign-magnitude; negative zero shifts output slightly
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ocstp_top #(
    parameter int SAMP_W = 14
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // register port
    input wire logic [ocstp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // pins from the capture side and calibration
    input wire logic OUTPUT_CLOCK_SYNC_RESET,
    input wire logic CALIBRATION_ACTIVE,
    // converted samples, 4 fraction bits
    input wire logic signed [SAMP_W-1:0] SAMPLE_I,
    input wire logic signed [SAMP_W-1:0] SAMPLE_Q,
    // output buses
    output logic [7:0] CHANNEL_ONE_BUS,
    output logic [7:0] CHANNEL_TWO_BUS,
    output logic [7:0] CHANNEL_ONE_LATE_BUS,
    output logic [7:0] CHANNEL_TWO_LATE_BUS,
    output logic RANGE_FLAG,
    output logic OUTPUT_DATA_CLOCK
);
    import ocstp_pkg::*;

    if (SAMP_W < 13 || SAMP_W > 20) begin : g_chk
        $error("SAMP_W out of range");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic rst_s1_r, rst_s2_r, cal_s1_r, cal_s2_r;
    // two flops per pin; assertion is taken whenever it arrives
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
            cal_s1_r <= 1'b0;
            cal_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= OUTPUT_CLOCK_SYNC_RESET;
            rst_s2_r <= rst_s1_r;
            cal_s1_r <= CALIBRATION_ACTIVE;
            cal_s2_r <= cal_s1_r;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [4:0] ctrl_r, ctrl_nxt;
    logic [OFFS_W-1:0] offs_r [2];
    logic [OFFS_W-1:0] offs_nxt [2];
    logic [31:0] rdata_nxt;
    ocstp_state_t st_r, st_nxt;
    logic demux, ddr, edge_sel, clk_run, test_en;
    assign demux = ctrl_r[CTRL_DEMUX];
    assign ddr = ctrl_r[CTRL_DDR];
    assign edge_sel = ctrl_r[CTRL_EDGE];
    assign clk_run = ctrl_r[CTRL_RUN];
    assign test_en = ctrl_r[CTRL_TEST];

    // decode writes and reads; unmapped reads return zero
    always_comb begin
        ctrl_nxt = ctrl_r;
        offs_nxt = offs_r;
        rdata_nxt = 32'h0;
        if (WR && ADDR == CTRL_OFS) begin
            ctrl_nxt = WDATA[4:0];
        end
        if (WR && ADDR == OFFS_OFS) begin
            offs_nxt[0] = WDATA[OFFS_W-1:0];
            offs_nxt[1] = WDATA[OFFS_Q_LSB+OFFS_W-1:OFFS_Q_LSB];
        end
        if (RD) begin
            unique case (ADDR)
                CTRL_OFS: rdata_nxt = {27'h0, ctrl_r};
                OFFS_OFS: rdata_nxt = {7'h0, offs_r[1], 7'h0, offs_r[0]};
                STAT_OFS: rdata_nxt = {28'h0, cal_s2_r, rst_s2_r, st_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    // register the bus state
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= CTRL_RST;
            offs_r[0] <= OFFS_RST;
            offs_r[1] <= OFFS_RST;
            RDATA <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            offs_r <= offs_nxt;
            RDATA <= rdata_nxt;
        end
    end

    // ****************************************
    // clock sync and output data clock
    // ****************************************
    logic [3:0] cnt_r, cnt_nxt, idx_r, idx_nxt;
    logic [1:0] ph_r, ph_nxt, last_ph;
    logic output_data_clock_nxt, hold_lvl, four_m, slot_en;
    assign hold_lvl = ddr ? ~edge_sel : edge_sel;
    assign four_m = demux & ddr & ~edge_sel;
    assign last_ph = demux ? SLOT_DMX_LAST : SLOT_NDM_LAST;
    assign slot_en = (st_r == OCSTP_RUN) && (ph_r == last_ph) && !rst_s2_r;

    // hold, wait, then restart the slot timing
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ph_nxt = ph_r;
        idx_nxt = idx_r;
        output_data_clock_nxt = OUTPUT_DATA_CLOCK;
        unique case (st_r)
            OCSTP_RUN: begin
                if (rst_s2_r) begin
                    st_nxt = OCSTP_HOLD;
                    output_data_clock_nxt = hold_lvl;
                end else begin
                    ph_nxt = (ph_r == last_ph) ? 2'h0 : ph_r + 2'h1;
                    if (slot_en) begin
                        if (idx_r >= (demux ? DMX_LAST : NDM_LAST)) begin
                            idx_nxt = 4'h0;
                        end else begin
                            idx_nxt = idx_r + 4'h1;
                        end
                    end
                    if (cal_s2_r && !clk_run) begin
                        output_data_clock_nxt = hold_lvl;
                    end else if (ddr) begin
                        output_data_clock_nxt = slot_en ? ~OUTPUT_DATA_CLOCK : OUTPUT_DATA_CLOCK;
                    end else begin
                        output_data_clock_nxt = edge_sel ^ (ph_nxt <= (last_ph >> 1));
                    end
                end
            end
            OCSTP_HOLD: begin
                output_data_clock_nxt = hold_lvl;
                ph_nxt = 2'h0;
                idx_nxt = 4'h0;
                if (!rst_s2_r) begin
                    st_nxt = OCSTP_WAIT;
                    cnt_nxt = (four_m ? WAIT_DDR0 : WAIT_OTHER) + 4'(TOD_CYC - 1);
                end
            end
            OCSTP_WAIT: begin
                output_data_clock_nxt = hold_lvl;
                if (rst_s2_r) begin
                    st_nxt = OCSTP_HOLD;
                end else if (cnt_r == 4'h0) begin
                    st_nxt = OCSTP_RUN;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
        endcase
    end

    // register the sync state
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= OCSTP_RUN;
            cnt_r <= 4'h0;
            ph_r <= 2'h0;
            idx_r <= 4'h0;
            OUTPUT_DATA_CLOCK <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ph_r <= ph_nxt;
            idx_r <= idx_nxt;
            OUTPUT_DATA_CLOCK <= output_data_clock_nxt;
        end
    end

    // ****************************************
    // offset, clipping and range per channel
    // ****************************************
    logic signed [SAMP_W-1:0] samp [2];
    logic [7:0] code [2];
    logic [1:0] ov_hi, ov_lo;
    assign samp[0] = SAMPLE_I;
    assign samp[1] = SAMPLE_Q;
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic signed [SAMP_W+1:0] adj, sum;
        // sign-magnitude offset; negative zero still moves the output
        always_comb begin
            adj = (SAMP_W+2)'(offs_r[c][7:0]);
            if (offs_r[c][8]) begin
                adj = -adj - (SAMP_W+2)'(NEG_ZERO_STEP);
            end
            sum = (SAMP_W+2)'(samp[c]) + adj;
        end
        assign ov_lo[c] = sum < 0;
        assign ov_hi[c] = (sum >>> FRAC_W) > 255;
        assign code[c] = ov_lo[c] ? 8'h00 : ov_hi[c] ? 8'hff : sum[FRAC_W+7:FRAC_W];
    end

    // ****************************************
    // output buses and test pattern
    // ****************************************
    logic [7:0] i_nxt, q_nxt, il_nxt, ql_nxt, ei_r, eq_r, ei_nxt, eq_nxt;
    logic rng_nxt, er_r, er_nxt, comp;
    assign comp = demux ? DMX_SEQ[idx_r[2:0]] : NDM_SEQ[idx_r];

    // capture the early sample mid-slot, drive all buses at slot end
    always_comb begin
        ei_nxt = ei_r;
        eq_nxt = eq_r;
        er_nxt = er_r;
        i_nxt = CHANNEL_ONE_BUS;
        q_nxt = CHANNEL_TWO_BUS;
        il_nxt = CHANNEL_ONE_LATE_BUS;
        ql_nxt = CHANNEL_TWO_LATE_BUS;
        rng_nxt = RANGE_FLAG;
        if (demux && ph_r == DMX_MID) begin
            ei_nxt = code[0];
            eq_nxt = code[1];
            er_nxt = |{ov_hi, ov_lo};
        end
        if (slot_en && test_en) begin
            // samples disconnected, interleave has no effect
            i_nxt = (demux ? PAT_I : PAT_IL) ^ {8{comp}};
            q_nxt = (demux ? PAT_Q : PAT_QL) ^ {8{comp}};
            il_nxt = demux ? PAT_IL ^ {8{comp}} : 8'h00;
            ql_nxt = demux ? PAT_QL ^ {8{comp}} : 8'h00;
            rng_nxt = comp;
        end else if (slot_en) begin
            i_nxt = code[0];
            q_nxt = code[1];
            il_nxt = demux ? ei_r : 8'h00;
            ql_nxt = demux ? eq_r : 8'h00;
            rng_nxt = (|{ov_hi, ov_lo}) | (demux & er_r);
        end
    end

    // register the data path; both channels share one slot count
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ei_r <= 8'h00;
            eq_r <= 8'h00;
            er_r <= 1'b0;
            CHANNEL_ONE_BUS <= 8'h00;
            CHANNEL_TWO_BUS <= 8'h00;
            CHANNEL_ONE_LATE_BUS <= 8'h00;
            CHANNEL_TWO_LATE_BUS <= 8'h00;
            RANGE_FLAG <= 1'b0;
        end else begin
            ei_r <= ei_nxt;
            eq_r <= eq_nxt;
            er_r <= er_nxt;
            CHANNEL_ONE_BUS <= i_nxt;
            CHANNEL_TWO_BUS <= q_nxt;
            CHANNEL_ONE_LATE_BUS <= il_nxt;
            CHANNEL_TWO_LATE_BUS <= ql_nxt;
            RANGE_FLAG <= rng_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    a_enter_hold: assert property (st_r == OCSTP_RUN && rst_s2_r |=> st_r == OCSTP_HOLD)
        else $error("sync reset not taken");
    a_hold_level: assert property (st_r == OCSTP_HOLD && $stable(ctrl_r)
        |=> OUTPUT_DATA_CLOCK == $past(hold_lvl))
        else $error("data clock not at hold level");
    a_wait_four: assert property (st_r == OCSTP_HOLD && !rst_s2_r && four_m
        && $stable(ctrl_r) ##1 (!rst_s2_r && $stable(ctrl_r))[*5] |=> st_r == OCSTP_RUN)
        else $error("four cycle resync wrong");
    a_wait_three: assert property (st_r == OCSTP_HOLD && !rst_s2_r && !four_m
        ##1 (!rst_s2_r && $stable(ctrl_r))[*3] |=> st_r == OCSTP_WAIT ##1 st_r == OCSTP_RUN)
        else $error("three cycle resync wrong");
    a_stop_cal: assert property ((st_r == OCSTP_RUN && cal_s2_r && !clk_run && !rst_s2_r)
        [*2] |=> $stable(OUTPUT_DATA_CLOCK))
        else $error("data clock runs in calibration");
    a_pat_range: assert property ($past(slot_en) && $past(test_en) |-> RANGE_FLAG == CHANNEL_TWO_BUS[7])
        else $error("range flag does not follow pattern");
    a_pat_pair: assert property ($past(slot_en) && $past(test_en) && $past(demux)
        |-> CHANNEL_ONE_LATE_BUS == (CHANNEL_ONE_BUS ^ 8'h06))
        else $error("demux pattern words wrong");
    a_ndm_late: assert property ($past(slot_en) && $past(test_en) && !$past(demux)
        |-> CHANNEL_ONE_LATE_BUS == 8'h00 && CHANNEL_TWO_LATE_BUS == 8'h00)
        else $error("late buses driven in non-demux");
    a_clip_high: assert property (slot_en && !test_en && ov_hi[0]
        |=> CHANNEL_ONE_BUS == 8'hff && RANGE_FLAG)
        else $error("high clip missing");
    a_pat_start: assert property (st_r == OCSTP_WAIT ##1 (st_r == OCSTP_RUN && test_en
        && !demux && !rst_s2_r && $stable(ctrl_r))[*2]
        |=> CHANNEL_ONE_BUS == 8'h02 && !RANGE_FLAG)
        else $error("pattern did not start at base word");

    c_resync: cover property (st_r == OCSTP_WAIT ##1 st_r == OCSTP_RUN);
    c_dmx_pat: cover property (slot_en && test_en && demux && comp);
    c_clip: cover property (slot_en && !test_en && ov_lo[1]);
    c_cal_stop: cover property (st_r == OCSTP_RUN && cal_s2_r && !clk_run);
endmodule : ocstp_top
`default_nettype wire

// [ocstp_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ocstp_top_tb;
    import ocstp_pkg::*;
    logic sys_clk, rstn, wr, rd, cal, want_rst, sync_rst, rflag, output_data_clock;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    logic signed [13:0] samp_i, samp_q;
    logic [7:0] ch1, ch2, ch1l, ch2l;
    logic [15:0] edge_cnt;
    int error_cnt = 0;
    int checks_done = 0;
    // ****************************************
    // design and capture model
    // ****************************************
    ocstp_top #(.SAMP_W(14)) ocstp_top_i (.SYS_CLK(sys_clk), .RSTN(rstn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .OUTPUT_CLOCK_SYNC_RESET(sync_rst),
        .CALIBRATION_ACTIVE(cal), .SAMPLE_I(samp_i), .SAMPLE_Q(samp_q), .CHANNEL_ONE_BUS(ch1),
        .CHANNEL_TWO_BUS(ch2), .CHANNEL_ONE_LATE_BUS(ch1l), .CHANNEL_TWO_LATE_BUS(ch2l),
        .RANGE_FLAG(rflag), .OUTPUT_DATA_CLOCK(output_data_clock));
    ocstp_capture ocstp_capture_i (.want_rst(want_rst), .cal_busy(cal), .data_clk(output_data_clock),
        .sync_rst(sync_rst), .edge_cnt(edge_cnt));
    // sampling clock, 8 ns
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic hang();
        error_cnt++;
        close_out();
    endtask : hang
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic do_reset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
    endtask : do_reset
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        cmp(what, exp, rdata);
    endtask : reg_rd
    // bounded wait until the sync pin shows v at a sampling edge
    task automatic wait_pin(input logic v);
        int k;
        k = 0;
        while (sync_rst !== v && k < 100) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 100) hang();
    endtask : wait_pin
    // ****************************************
    // scenarios
    // ****************************************
    task automatic regs();
        do_reset();
        reg_rd(CTRL_OFS, 32'h1, "control");
        reg_rd(OFFS_OFS, 32'h0, "offset");
        reg_rd(STAT_OFS, 32'h0, "status");
        reg_wr(OFFS_OFS, 32'hffffffff);
        reg_rd(OFFS_OFS, 32'h01ff01ff, "offset fields");
        reg_wr(4'hc, 32'hffffffff);
        reg_rd(4'hc, 32'h0, "unmapped");
        reg_wr(STAT_OFS, 32'hff);
        reg_rd(STAT_OFS, 32'h0, "status kept");
    endtask : regs
    // hold, release, resync delay, then ten slots of pattern
    task automatic resync(input logic [4:0] ctrl, input int exp_n);
        int n;
        int slot;
        logic comp;
        logic dmx;
        logic [7:0] b1;
        do_reset();
        want_rst <= 1'b1;
        wait_pin(1'b1);
        repeat (4) @(posedge sys_clk);
        reg_wr(CTRL_OFS, 32'(ctrl));
        reg_rd(STAT_OFS, 32'h5, "status held");
        for (n = 0; n < 4; n++) begin
            repeat (3) @(posedge sys_clk);
            #1;
            cmp("held clock", 32'(ctrl[CTRL_DDR] ^ ctrl[CTRL_EDGE]), 32'(output_data_clock));
            cmp("frozen bus", 32'h0, 32'(ch1));
        end
        @(posedge sys_clk);
        want_rst <= 1'b0;
        wait_pin(1'b0);
        n = 0;
        while (ch1 === 8'h00 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        cmp("resync delay", exp_n, n);
        dmx = ctrl[CTRL_DEMUX];
        slot = dmx ? 4 : 2;
        b1 = dmx ? 8'h04 : 8'h02;
        for (n = 0; n < 10; n++) begin
            comp = dmx ? (n % 5 == 1 || n % 5 == 3) : (n == 1 || n == 4 || n == 5 || n == 8);
            cmp("channel one", 32'(b1 ^ {8{comp}}), 32'(ch1));
            cmp("channel two", 32'((b1 - 8'h01) ^ {8{comp}}), 32'(ch2));
            cmp("one late", dmx ? 32'((b1 - 8'h02) ^ {8{comp}}) : 32'h0, 32'(ch1l));
            cmp("two late", dmx ? 32'((b1 - 8'h03) ^ {8{comp}}) : 32'h0, 32'(ch2l));
            cmp("pattern flag", 32'(comp), 32'(rflag));
            repeat (slot) @(posedge sys_clk);
            #1;
        end
    endtask : resync
    task automatic cal_stop();
        logic [15:0] c0;
        do_reset();
        cal <= 1'b1;
        repeat (6) @(posedge sys_clk);
        c0 = edge_cnt;
        repeat (40) @(posedge sys_clk);
        cmp("stopped clock", 32'(c0), 32'(edge_cnt));
        reg_wr(CTRL_OFS, 32'h9);
        repeat (40) @(posedge sys_clk);
        cmp("running clock", 32'h1, 32'(edge_cnt != c0));
        cal <= 1'b0;
    endtask : cal_stop
    task automatic conv(input logic signed [13:0] s, input logic [31:0] ofs, output logic [7:0] w);
        @(posedge sys_clk);
        samp_i <= s;
        reg_wr(OFFS_OFS, ofs);
        repeat (12) @(posedge sys_clk);
        #1;
        w = ch1;
    endtask : conv
    task automatic range_and_offset();
        logic [7:0] a;
        logic [7:0] b;
        int diff;
        do_reset();
        samp_q <= 14'sd2048;
        conv(14'sd8191, 32'h0, a);
        cmp("clip high", 32'hff, 32'(a));
        cmp("flag high", 32'h1, 32'(rflag));
        conv(-14'sd8192, 32'h0, a);
        cmp("clip low", 32'h0, 32'(a));
        cmp("flag low", 32'h1, 32'(rflag));
        conv(14'sd2048, 32'h0, a);
        cmp("mid code", 32'h80, 32'(a));
        cmp("flag clear", 32'h0, 32'(rflag));
        diff = 0;
        conv(14'sd2049, 32'h0, a);
        conv(14'sd2049, 32'h100, b);
        diff += int'(a) - int'(b);
        conv(14'sd2057, 32'h0, a);
        conv(14'sd2057, 32'h100, b);
        diff += int'(a) - int'(b);
        cmp("zero sign step", 32'h1, 32'(diff));
    endtask : range_and_offset
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = 32'h0;
        cal = 1'b0;
        want_rst = 1'b0;
        samp_i = 14'sd0;
        samp_q = 14'sd0;
        regs();
        resync(5'h10, 8);
        resync(5'h11, 10);
        resync(5'h13, 11);
        resync(5'h17, 10);
        resync(5'h15, 10);
        cal_stop();
        range_and_offset();
        close_out();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        hang();
    end
endmodule : ocstp_top_tb
`default_nettype wire
